//--- bench/aig_apb_master.sv
// apb host model that drives the block's register port
`timescale 1ns/1ps
`default_nettype none
module aig_apb_master (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // setup, access until ready, then one idle cycle with the bus scrambled
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic tmo);
    int   n;
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    rdy = 1'b0;
    q = 32'h0000_0000;
    // sample ready and data mid-cycle, where they stand for the coming edge
    while (!rdy && n < 16)
    begin
      @(negedge pclk);
      rdy = (pready === 1'b1);
      q = prdata;
      @(posedge pclk);
      n++;
    end
    tmo = !rdy;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- bench/aig_exec_checker.sv
// port-level assertions for the add group block
`timescale 1ns/1ps
`default_nettype none
module aig_exec_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic acc;
  logic rd;
  logic st;
  logic rs;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign acc = psel && penable;
  assign rd = acc && !pwrite;
  assign st = acc && pwrite && paddr == 12'h000 && pwdata[0];
  assign rs = psel && !penable && !pwrite;
  AST_READY: assert property (acc |-> pready) else $error("no ready");
  AST_NOERR: assert property (acc |-> !pslverr) else $error("slave error");
  AST_CTRL0: assert property (rd && paddr == 12'h000 |-> prdata == 32'h0000_0000) else $error("ctrl read");
  AST_UNMAP: assert property (rd && paddr > 12'h014 && paddr < 12'h040 |-> prdata == 32'h0000_0000)
    else $error("unmapped read");
  AST_HOLD: assert property (!rs |=> $stable(prdata)) else $error("read data moved");
  AST_REGRB: assert property ((acc && pwrite && paddr[11:6] == 6'h01) ##3 (rd && paddr == $past(paddr, 3))
    |-> prdata == $past(pwdata, 3)) else $error("register readback");
  AST_CCRRB: assert property ((acc && pwrite && paddr == 12'h014) ##3 (rd && paddr == 12'h014)
    |-> prdata[4:0] == $past(pwdata[4:0], 3)) else $error("flag readback");
  AST_BUSY: assert property (st ##3 (rd && paddr == 12'h014) |-> !prdata[7]) else $error("idle too early");
  AST_IDLE: assert property (st ##6 (rd && paddr == 12'h014) |-> prdata[7]) else $error("not idle");
  cover property (st);
  cover property (rd && paddr == 12'h024);
  cover property (acc && pwrite && paddr == 12'h014);
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the add group block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] v;
  logic [31:0] v0;
  int          n_errors;
  int          cmp_count;
  aig_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  aig_apb_master m (.pclk(pclk), .pready(pready), .prdata(prdata), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  task automatic print_verdict;
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hang;
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic t;
    m.xfer(w, a, d, v, t);
    if (t)
      hang();
  endtask
  // read data stands at the access edge
  task automatic rd(input logic [11:0] a);
    xf(1'b0, a, 32'h0000_0000);
  endtask
  task automatic run(input logic [15:0] op);
    int i;
    xf(1'b1, 12'h004, {16'h0000, op});
    xf(1'b1, 12'h000, 32'h0000_0001);
    rd(12'h014);
    v0 = v;
    for (i = 0; i < 8 && v[7] !== 1'b1; i++)
      rd(12'h014);
    if (v[7] !== 1'b1)
      hang();
  endtask
  task automatic sc_reset;
    rd(12'h014);
    chk(v, 32'h0000_0080);
    rd(12'h024);
    chk(v, 32'h0000_0000);
  endtask
  task automatic sc_add;
    xf(1'b1, 12'h04C, 32'h7FFF_FFFF);
    xf(1'b1, 12'h048, 32'h0000_0001);
    rd(12'h048);
    chk(v, 32'h0000_0001);
    run(16'hD682);
    rd(12'h04C);
    chk(v, 32'h8000_0000);
    rd(12'h014);
    chk(v, 32'h0000_008A);
    xf(1'b1, 12'h04C, 32'h1234_56FF);
    run(16'hD602);
    rd(12'h04C);
    chk(v, 32'h1234_5600);
    rd(12'h014);
    chk(v, 32'h0000_0095);
  endtask
  task automatic sc_add_to_address_reg;
    xf(1'b1, 12'h064, 32'h0000_1000);
    xf(1'b1, 12'h040, 32'h0000_8000);
    xf(1'b1, 12'h014, 32'h0000_001F);
    rd(12'h014);
    chk(v, 32'h0000_009F);
    run(16'hD2C0);
    rd(12'h064);
    chk(v, 32'hFFFF_9000);
    xf(1'b1, 12'h068, 32'h0000_0005);
    run(16'hD3CA);
    rd(12'h064);
    chk(v, 32'hFFFF_9005);
    rd(12'h014);
    chk(v, 32'h0000_009F);
  endtask
  task automatic sc_add_immediate;
    logic [1:0] s;
    for (s = 2'd0; s != 2'd3; s++)
    begin
      xf(1'b1, 12'h050, 32'h0000_0000);
      xf(1'b1, 12'h008, 32'h1234_5678);
      run({8'h06, s, 6'h04});
      rd(12'h050);
      chk(v, s[1] ? 32'h1234_5678 : (s[0] ? 32'h0000_5678 : 32'h0000_0078));
    end
  endtask
  // data register as add destination, byte from address register, pc destination, immediate to address register
  task automatic sc_illegal;
    logic [15:0] bad [4];
    int k;
    bad = '{16'hD702, 16'hD60A, 16'hD7BA, 16'h0688};
    for (k = 0; k < 4; k++)
    begin
      run(bad[k]);
      rd(12'h04C);
      chk(v, 32'h1234_5600);
      rd(12'h014);
      chk({31'h0000_0000, v[5]}, 32'h0000_0001);
    end
  endtask
  // memory destination, memory source and immediate source for general add
  task automatic sc_mem;
    xf(1'b1, 12'h010, 32'h0000_0100);
    xf(1'b1, 12'h00C, 32'h0000_0005);
    run(16'hD790);
    chk(v0, 32'h0000_0040);
    rd(12'h010);
    chk(v, 32'h1234_5700);
    run(16'hD6BC);
    rd(12'h04C);
    chk(v, 32'h2468_AC78);
    run(16'hD690);
    rd(12'h04C);
    chk(v, 32'h2468_AC7D);
    rd(12'h014);
    chk(v, 32'h0000_0080);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    n_errors = 0;
    cmp_count = 0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_reset();
    sc_add();
    sc_add_to_address_reg();
    sc_add_immediate();
    sc_illegal();
    sc_mem();
    print_verdict();
  end
endmodule
bind aig_exec aig_exec_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

//--- verilog/aig_exec.sv
// add instruction group decoder and executer with apb register access
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aig_params.svh"

module aig_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);
  import aig_pkg::*;

  typedef struct packed {
    logic [7:0][31:0] dreg;
    logic [7:0][31:0] areg;
    logic [15:0]      opcode;
    logic [31:0]      ext;
    logic [31:0]      src_mem;
    logic [31:0]      dst_mem;
    logic [31:0]      result;
    logic [4:0]       ccr;
    logic             illegal;
    logic             mem_wr;
    aig_state_t       state;
    logic [31:0]      rdata;
  } aig_state_s_t;

  aig_state_s_t s_q;
  aig_state_s_t s_d;

  // mask to operation size
  function automatic logic [31:0] aig_trim(input aig_size_t sz, input logic [31:0] v);
    case (sz)
      aig_sz_byte: aig_trim = {24'h00_0000, v[7:0]};
      aig_sz_word: aig_trim = {16'h0000, v[15:0]};
      default:     aig_trim = v;
    endcase
  endfunction

  // sign bit at operation size
  function automatic logic aig_msb(input aig_size_t sz, input logic [31:0] v);
    case (sz)
      aig_sz_byte: aig_msb = v[7];
      aig_sz_word: aig_msb = v[15];
      default:     aig_msb = v[31];
    endcase
  endfunction

  // merge a sized result into the old register value
  function automatic logic [31:0] aig_merge(input aig_size_t sz, input logic [31:0] old, input logic [31:0] v);
    case (sz)
      aig_sz_byte: aig_merge = {old[31:8], v[7:0]};
      aig_sz_word: aig_merge = {old[31:16], v[15:0]};
      default:     aig_merge = v;
    endcase
  endfunction

  // source modes: every mode, mode 111 only up to immediate
  function automatic logic aig_src_ok(input logic [2:0] mode, input logic [2:0] rg);
    aig_src_ok = (mode != `AIG_MODE_EXT) || (rg <= `AIG_EXT_IMM);
  endfunction

  // destination in mode 111: only the absolute forms are alterable
  function automatic logic aig_ext_alt(input logic [2:0] mode, input logic [2:0] rg);
    aig_ext_alt = (mode != `AIG_MODE_EXT) || (rg == `AIG_EXT_ABS_W) || (rg == `AIG_EXT_ABS_L);
  endfunction

  // register window hit: eight words from base
  function automatic logic aig_win(input logic [11:0] a, input logic [11:0] base);
    aig_win = (a[11:5] == base[11:5]);
  endfunction

  logic        wr_acc;
  logic        rd_setup;
  aig_kind_t   kind;
  aig_size_t   size;
  logic        ea_dest;
  logic [2:0]  ea_mode;
  logic [2:0]  ea_reg;
  logic [2:0]  rn;
  logic        legal;
  logic [31:0] ea_val;
  logic [31:0] src_v;
  logic [31:0] dst_v;
  logic [32:0] sum;
  logic [31:0] res;
  logic        carry;
  logic        ovf;
  logic        sm;
  logic        dm;
  logic        rm;

  assign wr_acc  = psel & penable & pwrite;
  // read data is latched in the setup cycle so it stands at the access edge
  // and stays until the next read is set up
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = s_q.rdata;

  assign ea_mode = s_q.opcode[5:3];
  assign ea_reg  = s_q.opcode[2:0];
  // register field at 11..9
  // register select
  assign rn      = s_q.opcode[11:9];

  always_comb
  begin
    kind    = aig_kind_none;
    size    = aig_sz_long;
    ea_dest = 1'b0;
    legal   = 1'b0;
    if (s_q.opcode[15:12] == `AIG_OP_ADD_HI)
    begin
      if (s_q.opcode[8:6] == `AIG_ADD_TO_ADDRESS_REG_WORD || s_q.opcode[8:6] == `AIG_ADD_TO_ADDRESS_REG_LONG)
      begin
        kind = aig_kind_add_to_address_reg;
        size = (s_q.opcode[8] ? aig_sz_long : aig_sz_word);
        legal = aig_src_ok(ea_mode, ea_reg);
      end
      else
      begin
        kind = aig_kind_add;
        ea_dest = s_q.opcode[8];
        size    = aig_size_t'(s_q.opcode[7:6]);
        if (ea_dest)
          legal = (ea_mode != `AIG_MODE_DREG) && (ea_mode != `AIG_MODE_AREG) && aig_ext_alt(ea_mode, ea_reg);
        else if (ea_mode == `AIG_MODE_AREG)
          legal = (size != aig_sz_byte);
        else
          legal = aig_src_ok(ea_mode, ea_reg);
      end
    end
    else if (s_q.opcode[15:8] == `AIG_OP_ADD_IMMEDIATE_HI)
    begin
      kind    = aig_kind_add_immediate;
      ea_dest = 1'b1;
      size    = aig_size_t'(s_q.opcode[7:6]);
      legal = (s_q.opcode[7:6] != 2'b11) && (ea_mode != `AIG_MODE_AREG) && aig_ext_alt(ea_mode, ea_reg);
    end
  end

  // operand at the effective address
  always_comb
  begin
    case (ea_mode)
      `AIG_MODE_DREG: ea_val = s_q.dreg[ea_reg];
      `AIG_MODE_AREG: ea_val = s_q.areg[ea_reg];
      `AIG_MODE_EXT:  ea_val = (ea_reg == `AIG_EXT_IMM) ? s_q.ext : s_q.src_mem;
      default:        ea_val = s_q.src_mem;
    endcase
  end

  always_comb
  begin
    src_v = 32'h0000_0000;
    dst_v = 32'h0000_0000;
    case (kind)
      aig_kind_add:
      begin
        src_v = ea_dest ? s_q.dreg[rn] : ea_val;
        dst_v = ea_dest ? s_q.dst_mem : s_q.dreg[rn];
      end
      aig_kind_add_to_address_reg:
      begin
        src_v = (size == aig_sz_word) ? {{16{ea_val[15]}}, ea_val[15:0]} : ea_val;
        dst_v = s_q.areg[rn];
      end
      aig_kind_add_immediate:
      begin
        src_v = s_q.ext;
        dst_v = (ea_mode == `AIG_MODE_DREG) ? s_q.dreg[ea_reg] : s_q.dst_mem;
      end
      default:
      begin
        src_v = 32'h0000_0000;
        dst_v = 32'h0000_0000;
      end
    endcase
  end

  always_comb
  begin
    if (kind == aig_kind_add_to_address_reg)
    begin
      sum = {1'b0, src_v} + {1'b0, dst_v};
      res = sum[31:0];
    end
    else
    begin
      sum = {1'b0, aig_trim(size, src_v)} + {1'b0, aig_trim(size, dst_v)};
      res = aig_trim(size, sum[31:0]);
    end
    case (size)
      aig_sz_byte: carry = sum[8];
      aig_sz_word: carry = sum[16];
      default:     carry = sum[32];
    endcase
    sm  = aig_msb(size, src_v);
    dm  = aig_msb(size, dst_v);
    rm  = aig_msb(size, res);
    ovf = (sm == dm) && (rm != sm);
  end

  always_comb
  begin
    s_d        = s_q;
    s_d.mem_wr = 1'b0;
    if (rd_setup)
    begin
      case (paddr)
        `AIG_APB_CTRL:   s_d.rdata = 32'h0000_0000;
        `AIG_APB_OPCODE: s_d.rdata = {16'h0000, s_q.opcode};
        `AIG_APB_EXT:    s_d.rdata = s_q.ext;
        `AIG_APB_SRC:    s_d.rdata = s_q.src_mem;
        `AIG_APB_DST:    s_d.rdata = s_q.result;
        `AIG_APB_STATUS: s_d.rdata = {24'h00_0000, s_q.state == aig_st_idle, s_q.mem_wr, s_q.illegal, s_q.ccr};
        default:
        begin
          if (aig_win(paddr, `AIG_APB_DREG_BASE))
            s_d.rdata = s_q.dreg[paddr[4:2]];
          else if (aig_win(paddr, `AIG_APB_AREG_BASE))
            s_d.rdata = s_q.areg[paddr[4:2]];
          else
            s_d.rdata = 32'h0000_0000;
        end
      endcase
    end
    // writes only land while idle, so operands cannot move under an execution
    if (wr_acc && s_q.state == aig_st_idle)
    begin
      case (paddr)
        `AIG_APB_OPCODE: s_d.opcode  = pwdata[15:0];
        `AIG_APB_EXT:    s_d.ext     = pwdata;
        `AIG_APB_SRC:    s_d.src_mem = pwdata;
        `AIG_APB_DST:    s_d.dst_mem = pwdata;
        `AIG_APB_STATUS: s_d.ccr     = pwdata[4:0];
        `AIG_APB_CTRL:   if (pwdata[0]) s_d.state = aig_st_exec;
        default:
        begin
          if (aig_win(paddr, `AIG_APB_DREG_BASE))
            s_d.dreg[paddr[4:2]] = pwdata;
          else if (aig_win(paddr, `AIG_APB_AREG_BASE))
            s_d.areg[paddr[4:2]] = pwdata;
        end
      endcase
    end
    case (s_q.state)
      aig_st_idle: ;
      aig_st_exec:
      begin
        s_d.state   = aig_st_done;
        s_d.illegal = ~legal;
        if (legal)
        begin
          case (kind)
            aig_kind_add_to_address_reg:
            begin
              s_d.areg[rn] = res;
              s_d.result   = res;
            end
            aig_kind_add, aig_kind_add_immediate:
            begin
              s_d.result = res;
              if (!ea_dest)
                s_d.dreg[rn] = aig_merge(size, s_q.dreg[rn], res);
              else if (kind == aig_kind_add_immediate && ea_mode == `AIG_MODE_DREG)
                s_d.dreg[ea_reg] = aig_merge(size, s_q.dreg[ea_reg], res);
              else
                s_d.mem_wr = 1'b1;
              s_d.ccr[`AIG_CCR_X] = carry;
              s_d.ccr[`AIG_CCR_N] = rm;
              s_d.ccr[`AIG_CCR_Z] = (res == 32'h0000_0000);
              s_d.ccr[`AIG_CCR_V] = ovf;
              s_d.ccr[`AIG_CCR_C] = carry;
            end
            default: ;
          endcase
        end
      end
      aig_st_done: s_d.state = aig_st_idle;
      default:     s_d.state = aig_st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q       <= '0;
      s_q.ccr   <= `AIG_CCR_RESET;
      s_q.state <= aig_st_idle;
    end
    else
      s_q <= s_d;
  end
endmodule
`default_nettype wire

//--- verilog/aig_params.svh
// constants for the add instruction group decoder and executer
`ifndef AIG_PARAMS_SVH
`define AIG_PARAMS_SVH
`define AIG_OP_ADD_HI        4'b1101
`define AIG_OP_ADD_IMMEDIATE_HI       8'b0000_0110
`define AIG_ADD_TO_ADDRESS_REG_WORD        3'b011
`define AIG_ADD_TO_ADDRESS_REG_LONG        3'b111
`define AIG_MODE_DREG        3'b000
`define AIG_MODE_AREG        3'b001
`define AIG_MODE_EXT         3'b111
`define AIG_EXT_ABS_W        3'b000
`define AIG_EXT_ABS_L        3'b001
`define AIG_EXT_PC_DISP      3'b010
`define AIG_EXT_PC_IDX       3'b011
`define AIG_EXT_IMM          3'b100
`define AIG_CCR_X            4
`define AIG_CCR_N            3
`define AIG_CCR_Z            2
`define AIG_CCR_V            1
`define AIG_CCR_C            0
`define AIG_CCR_RESET        5'h00
`define AIG_REG_RESET        32'h0000_0000
`define AIG_APB_CTRL         12'h000
`define AIG_APB_OPCODE       12'h004
`define AIG_APB_EXT          12'h008
`define AIG_APB_SRC          12'h00C
`define AIG_APB_DST          12'h010
`define AIG_APB_STATUS       12'h014
`define AIG_APB_DREG_BASE    12'h040
`define AIG_APB_AREG_BASE    12'h060
`endif

//--- verilog/aig_pkg.sv
// types for the add instruction group decoder and executer
package aig_pkg;
  typedef enum logic [1:0] {aig_sz_byte = 2'b00, aig_sz_word = 2'b01, aig_sz_long = 2'b10} aig_size_t;
  typedef enum logic [3:0] {
    aig_kind_none  = 4'b0001,
    aig_kind_add   = 4'b0010,
    aig_kind_add_to_address_reg  = 4'b0100,
    aig_kind_add_immediate  = 4'b1000
  } aig_kind_t;
  typedef enum logic [2:0] {aig_st_idle = 3'b001, aig_st_exec = 3'b010, aig_st_done = 3'b100} aig_state_t;
endpackage
